/* core/fdc_mode_perpendicular_config.sv */
`timescale 1ns/1ns
module fdc_mode_perpendicular_config #(
  parameter logic [3:0] VERSION = 4'h3 // arbitrary
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic soft_reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic density_polarity,
  input wire logic [1:0] data_rate,
  input wire logic [1:0] active_drive,
  input wire logic seek_done,
  input wire logic [7:0] scan_host_byte,
  input wire logic [7:0] scan_disk_byte,
  output logic scan_match,
  output logic settle_done,
  output logic density_select_out,
  output logic drive_buffer_opendrain,
  output logic [3:0] drive_perp,
  output logic [7:0] format_gap2_len,
  output logic [7:0] write_gap2_rewrite,
  output logic precomp_zero
);
  // command phase of the byte sequencer
  typedef enum {ST_IDLE, ST_MODE_PARM, ST_PERP_PARM} cmd_state_t;

  cmd_state_t state_r;
  fdc_cfg_pkg::features_t feat_r;
  fdc_cfg_pkg::drive_mode_t dmode_r;
  logic [2:0] parm_cnt_r;
  logic [7:0] result_r;
  logic res_valid_r;
  logic [31:0] settle_cnt_r;
  logic settling_r;
  // pin synchronisers
  logic seek_s1_r;
  logic seek_s2_r;
  logic seek_s3_r;
  logic pol_s1_r;
  logic pol_s2_r;
  // bus data-phase state
  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] addr_r;
  // decoded values
  logic [3:0] perp_nxt;
  logic grp_perp;
  logic grp_clear;
  logic [7:0] stat_word;
  logic [31:0] mult_us;
  logic [7:0] wbyte;
  logic is_high_rate;
  logic cmd_wr;
  logic res_rd;

  // refuse constants that the timer, the sequencer or the gap figures cannot serve
  if (fdc_cfg_pkg::CYC_PER_US < 1) begin : g_chk_clk
    $error("clock too slow for the settle timer");
  end
  if (fdc_cfg_pkg::MODE_BYTES < 3'd3) begin : g_chk_mode
    $error("mode command too short for the features byte");
  end
  if (64'(4'hf) * 64'(fdc_cfg_pkg::MULT_250_US) *
      64'(fdc_cfg_pkg::CYC_PER_US) > 64'hffff_ffff) begin : g_chk_settle
    $error("longest settle time overflows the counter");
  end
  if (fdc_cfg_pkg::RW_HIGH >= fdc_cfg_pkg::GAP2_PERP) begin : g_chk_gap
    $error("rewritten tail longer than the fast gap 2");
  end
  if (fdc_cfg_pkg::RW_LOW >= fdc_cfg_pkg::GAP2_STD) begin : g_chk_gap_low
    $error("rewritten tail longer than the standard gap 2");
  end

  // bus address phase capture
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= hsel && htrans[1] && hwrite;
      rd_pend_r <= hsel && htrans[1] && !hwrite;
      addr_r <= haddr[7:0];
    end
  end

  // data-phase decode of command writes and result reads
  assign wbyte = hwdata[7:0];
  assign cmd_wr = wr_pend_r && (addr_r == fdc_cfg_pkg::ADDR_CMD);
  assign res_rd = rd_pend_r && (addr_r == fdc_cfg_pkg::ADDR_RES);

  // zero-wait slave, always OKAY
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // status byte assembled by bit position
  always_comb begin
    stat_word = 8'h00;
    stat_word[fdc_cfg_pkg::ST_RES_VALID] = res_valid_r;
    stat_word[fdc_cfg_pkg::ST_BUSY] = (state_r != ST_IDLE);
    stat_word[fdc_cfg_pkg::ST_SETTLE] = settling_r;
  end

  // read data, registered from the address phase
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      hrdata <= 32'h0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        fdc_cfg_pkg::ADDR_RES: hrdata <= {24'h0, result_r};
        fdc_cfg_pkg::ADDR_STAT: hrdata <= {24'h0, stat_word};
        fdc_cfg_pkg::ADDR_CTRL: hrdata <= {24'h0, feat_r};
        fdc_cfg_pkg::ADDR_DRV: hrdata <= {26'h0, dmode_r};
        fdc_cfg_pkg::ADDR_SEEK: hrdata <= settle_cnt_r;
        default: hrdata <= 32'h0;
      endcase
    end
  end

  // command sequencer: mode features take effect on the third of four parameter bytes
  always_ff @(posedge clk_sys) begin
    if (!resetn || soft_reset) begin
      state_r <= ST_IDLE;
    end else if (cmd_wr) begin
      case (state_r)
        ST_IDLE: begin
          if (wbyte == fdc_cfg_pkg::OP_MODE)
            state_r <= ST_MODE_PARM;
          else if (wbyte == fdc_cfg_pkg::OP_PERP)
            state_r <= ST_PERP_PARM;
        end
        ST_MODE_PARM: begin
          if (parm_cnt_r == fdc_cfg_pkg::MODE_BYTES - 3'd1)
            state_r <= ST_IDLE;
        end
        ST_PERP_PARM: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // parameter byte counter of the mode command
  always_ff @(posedge clk_sys) begin
    if (!resetn || soft_reset) begin
      parm_cnt_r <= 3'd0;
    end else if (cmd_wr && state_r == ST_MODE_PARM) begin
      parm_cnt_r <= parm_cnt_r + 3'd1;
    end else if (cmd_wr && state_r == ST_IDLE) begin
      parm_cnt_r <= 3'd0;
    end
  end

  // features byte is the third parameter of the mode command
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      feat_r <= {fdc_cfg_pkg::DENS_DEFAULT, 1'b0, 1'b0,
        fdc_cfg_pkg::SETTLE_DEFAULT};
    end else if (cmd_wr && state_r == ST_MODE_PARM &&
        parm_cnt_r == 3'd2) begin
      feat_r <= wbyte;
    end
  end

  // drive-mode store
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      dmode_r <= '0;
    end else if (cmd_wr && state_r == ST_PERP_PARM) begin
      dmode_r.group_drive_mode <= wbyte[1:0];
      if (wbyte[fdc_cfg_pkg::PB_OVR])
        dmode_r.per_drive_mode_bits <= wbyte[5:2];
      // overwrite clear keeps stored bits
    end else if (soft_reset) begin
      dmode_r.group_drive_mode <= 2'b00;
    end
  end

  // identification result and invalid opcodes
  always_ff @(posedge clk_sys) begin
    if (!resetn || soft_reset) begin
      result_r <= 8'h00;
      res_valid_r <= 1'b0;
    end else if (cmd_wr && state_r == ST_IDLE &&
        wbyte == fdc_cfg_pkg::OP_IDENT) begin
      result_r <= {fdc_cfg_pkg::IDENT_MAKER, VERSION};
      res_valid_r <= 1'b1;
    end else if (cmd_wr && state_r == ST_IDLE &&
        wbyte != fdc_cfg_pkg::OP_MODE && wbyte != fdc_cfg_pkg::OP_PERP) begin
      result_r <= fdc_cfg_pkg::OP_INVALID;
      res_valid_r <= 1'b1;
    end else if (res_rd) begin
      res_valid_r <= 1'b0;
    end
  end

  // seek-complete synchroniser plus edge history
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      seek_s1_r <= 1'b0;
      seek_s2_r <= 1'b0;
      seek_s3_r <= 1'b0;
    end else begin
      seek_s1_r <= seek_done;
      seek_s2_r <= seek_s1_r;
      seek_s3_r <= seek_s2_r;
    end
  end

  // density polarity pin synchroniser
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pol_s1_r <= 1'b0;
      pol_s2_r <= 1'b0;
    end else begin
      pol_s1_r <= density_polarity;
      pol_s2_r <= pol_s1_r;
    end
  end

  // multiplier per rate in microseconds
  always_comb begin
    case (data_rate)
      fdc_cfg_pkg::RATE_250: mult_us = 32'(fdc_cfg_pkg::MULT_250_US);
      fdc_cfg_pkg::RATE_300: mult_us = 32'(fdc_cfg_pkg::MULT_300_US);
      fdc_cfg_pkg::RATE_500: mult_us = 32'(fdc_cfg_pkg::MULT_500_US);
      default: mult_us = 32'(fdc_cfg_pkg::MULT_1000_US);
    endcase
  end

  // settle timer started by the seek-complete edge
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      settle_cnt_r <= 32'h0;
      settling_r <= 1'b0;
      settle_done <= 1'b0;
    end else begin
      settle_done <= 1'b0;
      if (seek_s2_r && !seek_s3_r) begin
        settle_cnt_r <= 32'(feat_r.settle) * mult_us *
          32'(fdc_cfg_pkg::CYC_PER_US);
        settling_r <= 1'b1;
      end else if (settling_r) begin
        if (settle_cnt_r <= 32'h1) begin
          settling_r <= 1'b0;
          settle_done <= 1'b1;
        end else begin
          settle_cnt_r <= settle_cnt_r - 32'h1;
        end
      end
    end
  end

  // scan comparison with optional wildcard
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      scan_match <= 1'b0;
    end else if (!feat_r.scan_wildcard_disable &&
        (scan_host_byte == 8'hff || scan_disk_byte == 8'hff)) begin
      scan_match <= 1'b1;
    end else begin
      scan_match <= (scan_host_byte == scan_disk_byte);
    end
  end

  // drive buffer type output
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      drive_buffer_opendrain <= 1'b0;
    end else begin
      drive_buffer_opendrain <= feat_r.drive_buffer_opendrain;
    end
  end

  // density select output
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      density_select_out <= 1'b0;
    end else begin
      case (feat_r.dens_sel)
        fdc_cfg_pkg::DENS_LOW: density_select_out <= 1'b0;
        fdc_cfg_pkg::DENS_HIGH: density_select_out <= 1'b1;
        fdc_cfg_pkg::DENS_DEFAULT: density_select_out <= pol_s2_r;
        default: density_select_out <= 1'b0;
      endcase
    end
  end

  // group decode shared by every drive
  always_comb begin
    grp_perp = 1'b0;
    grp_clear = 1'b0;
    case (dmode_r.group_drive_mode)
      fdc_cfg_pkg::GRP_P500, fdc_cfg_pkg::GRP_P1M: grp_perp = 1'b1;
      2'b00: grp_clear = 1'b1;
      default: grp_perp = 1'b0;
    endcase
  end

  // effective mode, one copy per logical drive
  for (genvar d = 0; d < 4; d++) begin : g_drive
    assign perp_nxt[d] = grp_perp ||
      (grp_clear && dmode_r.per_drive_mode_bits[d]);
  end

  // fast class: group 11, or per-drive mode at the 1 Mbps rate
  assign is_high_rate =
    (dmode_r.group_drive_mode == fdc_cfg_pkg::GRP_P1M) ||
    (grp_clear && data_rate == fdc_cfg_pkg::RATE_1000);

  // effective mode of every drive and precompensation for the active drive
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      drive_perp <= 4'h0;
      precomp_zero <= 1'b0;
    end else begin
      drive_perp <= perp_nxt;
      precomp_zero <= perp_nxt[active_drive];
    end
  end

  // gap figures for the active drive
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      format_gap2_len <= fdc_cfg_pkg::GAP2_STD;
      write_gap2_rewrite <= fdc_cfg_pkg::RW_NONE;
    end else begin
      if (perp_nxt[active_drive] && is_high_rate) begin
        format_gap2_len <= fdc_cfg_pkg::GAP2_PERP;
        write_gap2_rewrite <= fdc_cfg_pkg::RW_HIGH;
      end else if (perp_nxt[active_drive]) begin
        format_gap2_len <= fdc_cfg_pkg::GAP2_STD;
        write_gap2_rewrite <= fdc_cfg_pkg::RW_LOW;
      end else begin
        format_gap2_len <= fdc_cfg_pkg::GAP2_STD;
        write_gap2_rewrite <= fdc_cfg_pkg::RW_NONE;
      end
    end
  end
endmodule : fdc_mode_perpendicular_config

/* core/fdc_cfg_pkg.sv */
package fdc_cfg_pkg;
  // register byte addresses on the bus
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_RES = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_DRV = 8'h10;
  localparam logic [7:0] ADDR_SEEK = 8'h14;
  // opcodes
  localparam logic [7:0] OP_MODE = 8'h01;
  localparam logic [7:0] OP_IDENT = 8'h18;
  localparam logic [7:0] OP_PERP = 8'h12;
  localparam logic [7:0] OP_INVALID = 8'h80;
  localparam logic [2:0] MODE_BYTES = 3'd4;
  // identification: upper nibble arbitrary, low nibble the version
  localparam logic [3:0] IDENT_MAKER = 4'h5;
  // features byte fields
  localparam int FB_WILD = 4;
  localparam int FB_BUF = 5;
  localparam logic [3:0] SETTLE_DEFAULT = 4'h8;
  localparam logic [1:0] DENS_DEFAULT = 2'b11;
  localparam logic [1:0] DENS_LOW = 2'b00;
  localparam logic [1:0] DENS_HIGH = 2'b01;
  // drive-mode byte fields
  localparam int PB_OVR = 7;
  localparam logic [1:0] GRP_P500 = 2'b01;
  localparam logic [1:0] GRP_P1M = 2'b11;
  // gap figures in bytes
  localparam logic [7:0] GAP2_STD = 8'h16;
  localparam logic [7:0] GAP2_PERP = 8'h29;
  localparam logic [7:0] RW_NONE = 8'h00;
  localparam logic [7:0] RW_LOW = 8'h13;
  localparam logic [7:0] RW_HIGH = 8'h26;
  // settle multipliers in 1/1000 ms units per factor step
  localparam int CLK_HZ = 50000000;
  localparam int MULT_250_US = 8000;
  localparam int MULT_300_US = 6666;
  localparam int MULT_500_US = 4000;
  localparam int MULT_1000_US = 2000;
  localparam int CYC_PER_US = CLK_HZ / 1000000;
  localparam logic [1:0] RATE_500 = 2'b00;
  localparam logic [1:0] RATE_300 = 2'b01;
  localparam logic [1:0] RATE_250 = 2'b10;
  localparam logic [1:0] RATE_1000 = 2'b11;
  // status bits
  localparam int ST_RES_VALID = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_SETTLE = 2;

  typedef struct packed {
    logic [1:0] dens_sel;
    logic drive_buffer_opendrain;
    logic scan_wildcard_disable;
    logic [3:0] settle;
  } features_t;

  typedef struct packed {
    logic [1:0] group_drive_mode;
    logic [3:0] per_drive_mode_bits;
  } drive_mode_t;
endpackage : fdc_cfg_pkg

/* verification/fdc_cfg_checker_assertions.sv */
`timescale 1ns/1ns
module fdc_cfg_checker (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [7:0] scan_host_byte,
  input wire logic [7:0] scan_disk_byte,
  input wire logic scan_match,
  input wire logic settle_done,
  input wire logic [1:0] active_drive,
  input wire logic [3:0] drive_perp,
  input wire logic [7:0] format_gap2_len,
  input wire logic [7:0] write_gap2_rewrite,
  input wire logic precomp_zero
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // drive mode and selection held for two cycles
  sequence s_steady;
    drive_perp == $past(drive_perp, 2) && active_drive == $past(active_drive, 2);
  endsequence
  sequence s_pulse;
    settle_done ##1 !settle_done;
  endsequence
  property p_ready; hreadyout; endproperty
  property p_okay; !hresp; endproperty
  property p_eq;
    resetn && scan_host_byte == scan_disk_byte |=> scan_match;
  endproperty
  property p_noeq;
    resetn && scan_host_byte != scan_disk_byte &&
      scan_host_byte != 8'hff &&
      scan_disk_byte != 8'hff |=> !scan_match;
  endproperty
  property p_gap;
    format_gap2_len == 8'h16 || format_gap2_len == 8'h29;
  endproperty
  property p_rw;
    write_gap2_rewrite inside {8'h00, 8'h13, 8'h26};
  endproperty
  property p_precomp;
    s_steady |-> precomp_zero == drive_perp[active_drive];
  endproperty
  property p_conv;
    s_steady ##0 !drive_perp[active_drive] |-> write_gap2_rewrite == 8'h00;
  endproperty
  property p_settle; settle_done |-> s_pulse; endproperty
  a_ready: assert property (p_ready) else $error("bus stall");
  a_okay: assert property (p_okay) else $error("error response");
  a_eq: assert property (p_eq) else $error("equal bytes miss");
  a_noeq: assert property (p_noeq) else $error("false match");
  a_gap: assert property (p_gap) else $error("bad gap length");
  a_rw: assert property (p_rw) else $error("bad rewrite length");
  a_precomp: assert property (p_precomp) else $error("precomp wrong");
  a_conv: assert property (p_conv) else $error("rewrite on conv");
  a_settle: assert property (p_settle) else $error("long settle pulse");
endmodule : fdc_cfg_checker
bind fdc_mode_perpendicular_config fdc_cfg_checker chk_i (
  .clk_sys(clk_sys), .resetn(resetn), .hreadyout(hreadyout), .hresp(hresp),
  .scan_host_byte(scan_host_byte), .scan_disk_byte(scan_disk_byte),
  .scan_match(scan_match), .settle_done(settle_done),
  .active_drive(active_drive), .drive_perp(drive_perp),
  .format_gap2_len(format_gap2_len), .write_gap2_rewrite(write_gap2_rewrite),
  .precomp_zero(precomp_zero));

/* verification/ahb_host.sv */
`timescale 1ns/1ns
module ahb_host (
  input wire logic clk_sys,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel = 1'b0,
  output logic [31:0] haddr = 32'h0,
  output logic [1:0] htrans = 2'b00,
  output logic hwrite = 1'b0,
  output logic [2:0] hsize = 3'h2,
  output logic [31:0] hwdata = 32'h0
);
  // one word transfer; command bytes go one per call, in order
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [31:0] q);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk_sys); while (!hready);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge clk_sys); while (!hready);
    q = hrdata;
    hwdata <= ~hwdata; // stale data is not left on the bus
  endtask : xfer
endmodule : ahb_host

/* verification/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  logic clk_sys = 0, resetn = 0, soft_reset = 0, density_polarity = 0;
  logic seek_done = 0, pp, hi;
  logic [1:0] data_rate = 0, active_drive = 0, grp = 0;
  logic [3:0] per = 0;
  logic [7:0] scan_host_byte = 0, scan_disk_byte = 0, b, f;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hsel, hwrite, hrdy, hresp, sm, sd, dens, obuf, pz;
  logic [3:0] dp;
  logic [7:0] gap, rw;
  int num_errors = 0, total_checks = 0, seed = 2940, r32;
  int m[4] = '{4000, 6666, 8000, 2000};
  always #10 clk_sys = ~clk_sys;
  ahb_host host (.clk_sys(clk_sys), .hready(hrdy), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));
  fdc_mode_perpendicular_config dut (.clk_sys(clk_sys), .resetn(resetn),
    .soft_reset(soft_reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy),
    .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
    .density_polarity(density_polarity), .data_rate(data_rate),
    .active_drive(active_drive), .seek_done(seek_done),
    .scan_host_byte(scan_host_byte), .scan_disk_byte(scan_disk_byte),
    .scan_match(sm), .settle_done(sd), .density_select_out(dens),
    .drive_buffer_opendrain(obuf), .drive_perp(dp), .format_gap2_len(gap),
    .write_gap2_rewrite(rw), .precomp_zero(pz));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task wr(input logic [7:0] d);
    host.xfer(1'b1, 8'h00, d, q);
  endtask : wr
  task rd(input logic [7:0] a);
    host.xfer(1'b0, a, 8'h00, q);
  endtask : rd
  task mode(input logic [7:0] v);
    for (int j = 0; j < 5; j++) wr(j == 0 ? 8'h01 : j == 3 ? v : 8'h00);
  endtask : mode
  // model of the effective drive mode versus the design outputs
  task outs;
    pp = grp[0] || grp == 2'b00 && per[active_drive];
    hi = grp == 2'b11 || grp == 2'b00 && data_rate == 2'b11;
    chk({28'h0, dp}, grp[0] ? 32'hf : grp[1] ? 32'h0 : {28'h0, per});
    chk({24'h0, gap}, pp && hi ? 32'd41 : 32'd22);
    chk({24'h0, rw}, !pp ? 32'd0 : hi ? 32'd38 : 32'd19);
    chk({31'h0, pz}, {31'h0, pp});
  endtask : outs
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  initial begin
    #400000;
    num_errors++;
    print_verdict;
  end
  initial begin
    cyc(8);
    resetn <= 1'b1;
    rd(8'h0c);
    chk(q, 32'hc8);
    rd(8'h10);
    chk(q, 32'h0);
    rd(8'h40);
    chk(q, 32'h0);
    wr(8'h18);
    rd(8'h04);
    chk(q, 32'h53);
    $display("test defaults and ident done");
    repeat (32) begin
      r32 = $random(seed);
      b = r32[7:0];
      data_rate <= r32[9:8];
      active_drive <= r32[11:10];
      wr(8'h12);
      wr(b);
      grp = b[1:0];
      if (b[7]) per = b[5:2];
      cyc(3);
      rd(8'h10);
      chk(q, {26'h0, grp, per});
      rd(8'h08);
      chk({31'h0, q[0]}, 32'h0);
      outs;
    end
    soft_reset <= 1'b1;
    cyc(1);
    soft_reset <= 1'b0;
    grp = 2'b00;
    cyc(3);
    rd(8'h10);
    chk(q, {28'h0, per});
    outs;
    $display("test drive mode done");
    for (int i = 0; i < 4; i++) begin
      f = {i[1:0], i[0], i[1], 4'h0};
      density_polarity <= i != 1;
      scan_host_byte <= i[0] ? 8'hff : 8'h00;
      scan_disk_byte <= i[0] ? 8'h00 : 8'hff;
      mode(f);
      cyc(4);
      chk({31'h0, dens}, {31'h0, i == 1 || i == 3});
      chk({31'h0, obuf}, {31'h0, f[5]});
      chk({31'h0, sm}, {31'h0, !f[4]});
    end
    $display("test features done");
    mode(8'hc1);
    for (int r = 0; r < 4; r++) begin
      data_rate <= r[1:0];
      seek_done <= 1'b1;
      cyc(4);
      rd(8'h14);
      chk({31'h0, q <= m[r] * 50 && q + 40 > m[r] * 50}, 32'h1);
      seek_done <= 1'b0;
      cyc(4);
    end
    mode(8'hc0);
    seek_done <= 1'b1;
    for (int k = 0; k < 40 && sd !== 1'b1; k++) @(negedge clk_sys);
    chk({31'h0, sd}, 32'h1);
    $display("test settle done");
    print_verdict;
  end
endmodule : tb_top
